// >>> logic/ucg_regs.vh
`ifndef UCG_REGS_VH
`define UCG_REGS_VH
// Register indices on the plain register port
`define UCG_ADDR_W 3
`define UCG_IDX_DIV_LOW 3'h0
`define UCG_IDX_DIV_HIGH 3'h1
`define UCG_IDX_CTRL_A 3'h2
`define UCG_IDX_CTRL_C 3'h3
`define UCG_IDX_POWER 3'h4
`define UCG_IDX_STATUS 3'h5
// Field positions
`define UCG_A_DOUBLE_SPEED 1
`define UCG_C_SYNC_MODE 6
`define UCG_C_POLARITY 0
`define UCG_C_PIN_DIR 1
`define UCG_PWR_CUT 0
// Divisor width and high byte mask
`define UCG_DIV_W 12
`define UCG_DIV_HIGH_MASK 8'h0F
// Reset values
`define UCG_POWER_RST 1'b1
// Receiver state counts and transmit divide factors
`define UCG_DIV_NORMAL 5'h10
`define UCG_DIV_DOUBLE 5'h08
`define UCG_DIV_SYNC 5'h02
// Clock modes
`define UCG_MODE_ASYNC 2'h0
`define UCG_MODE_DOUBLE 2'h1
`define UCG_MODE_MASTER 2'h2
`define UCG_MODE_SLAVE 2'h3
`endif

// >>> logic/ucg_clock_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "ucg_regs.vh"
// How it works
// RL1: Mode bit zero async, one sync
// RL2: Pin direction picks master or slave
// RL3: Transfer clock pin unused when asynchronous
// RL4: Counter reloads at zero or low write
// RL5: Pulse at zero, rate clk/(div+1)
// RL6: Divisor twelve bits from two bytes
// RL7: Transmit divides by 16, 8 or 2
// RL8: Receiver gets baud pulse, 2/8/16 states
// RL9: Software keeps double speed zero synchronous
// RL10: Double speed halves divide and samples
// RL11: Slave clock synchronised then edge detected
// RL12: External clock below quarter system clock
// RL13: Sample on edge opposite data change
// RL14: Polarity picks change and sample edges
// RL15: Software clears power cut before use
// RL16: Master drives pin; slave uses edges
module ucg_clock_gen (
  input wire clk,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire transfer_clock_pin_in,
  output reg transfer_clock_pin_out,
  output reg transfer_clock_pin_oe_n,
  output reg tx_bit_tick,
  output reg tx_change_tick,
  output reg rx_base_tick,
  output reg rx_sample_tick,
  output reg [4:0] rx_state_count,
  output reg [1:0] clock_mode,
  output reg unit_enable
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [7:0] baud_divisor_low_r;
  reg [3:0] baud_divisor_high_r;
  reg double_speed_bit_r;
  reg sync_mode_select_r;
  reg sync_clock_polarity_r;
  reg xfer_clock_pin_direction_r;
  reg power_cut_r;
  wire low_wr;
  wire [`UCG_DIV_W-1:0] baud_divisor;

  assign low_wr = reg_wr && (reg_addr == `UCG_IDX_DIV_LOW);
  // RL6: twelve-bit divisor
  assign baud_divisor = {baud_divisor_high_r, baud_divisor_low_r};

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------

  // Decodes the clocking mode from control bits
  function [1:0] mode_of;
    input sync_sel;
    input pin_dir;
    input dbl;
    begin
      // RL1: mode select
      if (!sync_sel) begin
        mode_of = dbl ? `UCG_MODE_DOUBLE : `UCG_MODE_ASYNC;
      end else begin
        // RL2: pin direction picks source; RL9 double speed ignored
        mode_of = pin_dir ? `UCG_MODE_MASTER : `UCG_MODE_SLAVE;
      end
    end
  endfunction

  wire [1:0] mode;
  assign mode = mode_of(sync_mode_select_r, xfer_clock_pin_direction_r, double_speed_bit_r);

  // Software writes; high byte bits above divisor dropped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_divisor_low_r <= 8'h00;
      baud_divisor_high_r <= 4'h0;
      double_speed_bit_r <= 1'b0;
      sync_mode_select_r <= 1'b0;
      sync_clock_polarity_r <= 1'b0;
      xfer_clock_pin_direction_r <= 1'b0;
      power_cut_r <= `UCG_POWER_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `UCG_IDX_DIV_LOW: begin
          baud_divisor_low_r <= reg_wdata;
        end
        `UCG_IDX_DIV_HIGH: begin
          baud_divisor_high_r <= reg_wdata[3:0];
        end
        `UCG_IDX_CTRL_A: begin
          double_speed_bit_r <= reg_wdata[`UCG_A_DOUBLE_SPEED];
        end
        `UCG_IDX_CTRL_C: begin
          sync_mode_select_r <= reg_wdata[`UCG_C_SYNC_MODE];
          sync_clock_polarity_r <= reg_wdata[`UCG_C_POLARITY];
          xfer_clock_pin_direction_r <= reg_wdata[`UCG_C_PIN_DIR];
        end
        `UCG_IDX_POWER: begin
          power_cut_r <= reg_wdata[`UCG_PWR_CUT];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  reg [`UCG_DIV_W-1:0] baud_cnt_r;
  wire baud_zero;
  assign baud_zero = (baud_cnt_r == {`UCG_DIV_W{1'b0}});

  // RL4: reload on zero or low byte write
  // Low write wins so a new rate starts at once
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_cnt_r <= {`UCG_DIV_W{1'b0}};
    end else if (low_wr) begin
      baud_cnt_r <= {baud_divisor_high_r, reg_wdata};
    end else if (baud_zero) begin
      baud_cnt_r <= baud_divisor;
    end else begin
      baud_cnt_r <= baud_cnt_r - 1'b1;
    end
  end

  // RL5: one pulse per zero, held off while powered down
  wire baud_pulse;
  assign baud_pulse = baud_zero && !low_wr && !power_cut_r;

  // ----------------------------------------
  // External clock path
  // ----------------------------------------
  reg xck_meta_r;
  reg xck_sync_r;
  reg xck_prev_r;
  wire ext_rise;
  wire ext_fall;

  // RL11: synchroniser then edge detector, two cycles late
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      xck_meta_r <= 1'b0;
      xck_sync_r <= 1'b0;
      xck_prev_r <= 1'b0;
    end else begin
      xck_meta_r <= transfer_clock_pin_in;
      xck_sync_r <= xck_meta_r;
      xck_prev_r <= xck_sync_r;
    end
  end
  // Edges compared on synced copies only, never the raw pin
  assign ext_rise = xck_sync_r && !xck_prev_r;
  assign ext_fall = !xck_sync_r && xck_prev_r;

  // ----------------------------------------
  // Transmit divider and master clock
  // ----------------------------------------
  reg [3:0] tx_div_r;
  reg xcko_r;
  wire [4:0] factor;
  wire [3:0] last;
  wire tx_wrap;

  // RL7: divide factor; RL10: double speed halves it
  assign factor = (mode == `UCG_MODE_ASYNC) ? `UCG_DIV_NORMAL :
                  (mode == `UCG_MODE_DOUBLE) ? `UCG_DIV_DOUBLE : `UCG_DIV_SYNC;
  assign last = factor[3:0] - 4'h1;
  assign tx_wrap = baud_pulse && (tx_div_r >= last);

  // Counts baud pulses; restarting on any compare keeps mode changes safe
  // Holds while powered down and resumes where it stopped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_div_r <= 4'h0;
      xcko_r <= 1'b0;
    end else if (baud_pulse) begin
      tx_div_r <= tx_wrap ? 4'h0 : tx_div_r + 4'h1;
      // RL16: master pin toggles each baud pulse, period = tx bit
      if (mode == `UCG_MODE_MASTER) begin
        xcko_r <= ~xcko_r;
      end else begin
        xcko_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transfer clock edges
  // ----------------------------------------
  reg xck_rise;
  reg xck_fall;
  reg change_edge;
  reg sample_edge;

  // Edges of the active transfer clock, internal or external
  always @* begin
    xck_rise = 1'b0;
    xck_fall = 1'b0;
    if (mode == `UCG_MODE_MASTER) begin
      xck_rise = baud_pulse && !xcko_r;
      xck_fall = baud_pulse && xcko_r;
    end else if (mode == `UCG_MODE_SLAVE) begin
      // RL16: slave timing only from detected edges
      xck_rise = ext_rise && !power_cut_r;
      xck_fall = ext_fall && !power_cut_r;
    end
    // RL14: polarity picks change and sample edges
    // RL13: sample on the opposite edge
    change_edge = sync_clock_polarity_r ? xck_fall : xck_rise;
    sample_edge = sync_clock_polarity_r ? xck_rise : xck_fall;
  end

  // ----------------------------------------
  // Mode and status outputs
  // ----------------------------------------
  // Registered copies so the outputs see no decode glitches
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_mode <= `UCG_MODE_ASYNC;
      unit_enable <= 1'b0;
    end else begin
      clock_mode <= mode;
      unit_enable <= !power_cut_r;
    end
  end

  // RL8: receiver state count follows mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_count <= `UCG_DIV_NORMAL;
    end else begin
      rx_state_count <= factor;
    end
  end

  // ----------------------------------------
  // Transmit ticks
  // ----------------------------------------
  // Sync modes tick on the change edge, async on the divider wrap
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_bit_tick <= 1'b0;
      tx_change_tick <= 1'b0;
    end else if (mode[1]) begin
      tx_bit_tick <= change_edge;
      tx_change_tick <= change_edge;
    end else begin
      tx_bit_tick <= tx_wrap;
      tx_change_tick <= tx_wrap;
    end
  end

  // ----------------------------------------
  // Receive ticks
  // ----------------------------------------
  // RL8: base clock straight from baud pulse or pin edges
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_base_tick <= 1'b0;
    end else if (mode[1]) begin
      rx_base_tick <= xck_rise || xck_fall;
    end else begin
      rx_base_tick <= baud_pulse;
    end
  end

  // RL13: sample tick only where a transfer clock exists
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sample_tick <= 1'b0;
    end else if (mode[1]) begin
      rx_sample_tick <= sample_edge;
    end else begin
      rx_sample_tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transfer clock pin
  // ----------------------------------------
  // RL3: pin driven only in synchronous master mode
  // Undriven value held low so no stale level leaks out
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      transfer_clock_pin_out <= 1'b0;
      transfer_clock_pin_oe_n <= 1'b1;
    end else begin
      transfer_clock_pin_out <= (mode == `UCG_MODE_MASTER) ? xcko_r : 1'b0;
      transfer_clock_pin_oe_n <= (mode != `UCG_MODE_MASTER);
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Read port, data one cycle after strobe
  // Idle value zero so a stale read never looks valid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `UCG_IDX_DIV_LOW: begin
          reg_rdata <= baud_divisor_low_r;
        end
        `UCG_IDX_DIV_HIGH: begin
          reg_rdata <= {4'h0, baud_divisor_high_r};
        end
        `UCG_IDX_CTRL_A: begin
          reg_rdata <= {6'h00, double_speed_bit_r, 1'b0};
        end
        `UCG_IDX_CTRL_C: begin
          reg_rdata <= {1'b0, sync_mode_select_r, 4'h0,
                        xfer_clock_pin_direction_r, sync_clock_polarity_r};
        end
        `UCG_IDX_POWER: begin
          reg_rdata <= {7'h00, power_cut_r};
        end
        `UCG_IDX_STATUS: begin
          reg_rdata <= {3'h0, xck_sync_r, 2'h0, mode};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // ucg_clock_gen
`default_nettype wire

// >>> testbench/ucg_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// Clock rules
// ----------
module ucg_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic transfer_clock_pin_in,
  input wire logic transfer_clock_pin_oe_n,
  input wire logic tx_bit_tick,
  input wire logic tx_change_tick,
  input wire logic rx_base_tick,
  input wire logic rx_sample_tick,
  input wire logic [4:0] rx_state_count,
  input wire logic [1:0] clock_mode,
  input wire logic unit_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_pin_drive: assert property (transfer_clock_pin_oe_n == (clock_mode != 2'h2))
    else $error("pin drive off mode");
  a_state_count: assert property (rx_state_count ==
    (clock_mode == 2'h0 ? 5'h10 : clock_mode == 2'h1 ? 5'h08 : 5'h02))
    else $error("state count off mode");
  a_async_nosample: assert property (!clock_mode[1] && !$past(clock_mode[1])
    |-> !rx_sample_tick) else $error("sample tick in async");
  a_edge_apart: assert property (!(tx_change_tick && rx_sample_tick))
    else $error("change and sample together");
  a_change_same: assert property (tx_change_tick == tx_bit_tick)
    else $error("change tick off bit tick");
  a_tick_single: assert property (tx_bit_tick |=> !tx_bit_tick)
    else $error("bit tick too long");
  a_power_gate: assert property (!unit_enable && $past(!unit_enable)
    |-> !rx_base_tick && !tx_bit_tick) else $error("tick while cut");
  a_slave_delay: assert property (clock_mode == 2'h3 && $rose(transfer_clock_pin_in)
    |-> ##[3:5] rx_base_tick) else $error("slave edge lost");
endmodule // ucg_chk

bind ucg_clock_gen ucg_chk u_chk (.clk(clk), .rst(rst),
  .transfer_clock_pin_in(transfer_clock_pin_in),
  .transfer_clock_pin_oe_n(transfer_clock_pin_oe_n),
  .tx_bit_tick(tx_bit_tick), .tx_change_tick(tx_change_tick),
  .rx_base_tick(rx_base_tick), .rx_sample_tick(rx_sample_tick),
  .rx_state_count(rx_state_count), .clock_mode(clock_mode),
  .unit_enable(unit_enable));
`default_nettype wire

// >>> testbench/ucg_xck_src.sv
`timescale 1ns/1ps
`default_nettype none
// Remote master clock, still outside frames
module ucg_xck_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] half,
  output logic xck_r
);
  logic [7:0] cnt_r;
  // half period of three or more
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      xck_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 8'h00;
    end else if (cnt_r + 8'h01 >= half) begin
      cnt_r <= 8'h00;
      xck_r <= ~xck_r;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // ucg_xck_src
`default_nettype wire

// >>> testbench/ucg_clock_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ucg_clock_gen_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] ad = 3'h0;
  logic [7:0] wd = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic run = 1'b0;
  logic [7:0] half = 8'h03;
  logic [31:0] lfsr = 32'hbeb1_ae87;
  wire [7:0] rdat;
  wire [4:0] st;
  wire [1:0] mode;
  wire po, oe_n, txb, txc, rxb, rxs, en, xck, pin;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int nrx = 0;
  int ntx = 0;
  int nrs = 0;
  int npo = 0;
  int nch = 0;
  logic po_q = 1'b0;
  int d;
  // Wire level: device wins while enabled
  assign pin = oe_n ? xck : po;
  always #2.5 clk = ~clk;
  ucg_clock_gen DUT (.clk(clk), .rst(rst), .reg_addr(ad), .reg_wdata(wd),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .transfer_clock_pin_in(pin),
    .transfer_clock_pin_out(po), .transfer_clock_pin_oe_n(oe_n), .tx_bit_tick(txb),
    .tx_change_tick(txc), .rx_base_tick(rxb), .rx_sample_tick(rxs),
    .rx_state_count(st), .clock_mode(mode), .unit_enable(en));
  ucg_xck_src u_src (.clk(clk), .rst(rst), .run(run), .half(half), .xck_r(xck));
  // Tick tallies and hang guard
  always @(posedge clk) begin
    nrx <= nrx + rxb;
    ntx <= ntx + txb;
    nrs <= nrs + rxs;
    nch <= nch + txc;
    po_q <= po;
    npo <= npo + (po != po_q);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    ad <= a;
    wd <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    ad <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdat;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts over a window may be off by one edge
  task automatic chkn(input int got, input int exp);
    samples_checked++;
    if (got < exp - 1 || got > exp + 1) begin
      errors++;
      $display("[FAIL] %0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [4:0] fac(input logic [1:0] m);
    return m == 2'h0 ? 5'h10 : m == 2'h1 ? 5'h08 : 5'h02;
  endfunction
  task automatic conclude();
    $display("errors=%0d checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Each mode and polarity with a random divisor
  initial begin
    logic [7:0] v;
    logic [1:0] m;
    int a;
    int b;
    int c;
    int e;
    int f;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(st, 5'h10);
    rd(3'h4, v);
    chk(v, 8'h01);
    rd(3'h6, v);
    chk(v, 8'h00);
    wr(3'h4, 8'h00);
    for (int k = 0; k < 8; k++) begin
      m = k[1:0];
      lfsr = nxt(lfsr);
      d = 2 + lfsr[1:0];
      half <= 8'(d + 1);
      wr(3'h1, {lfsr[7:4], 4'h0});
      rd(3'h1, v);
      chk(v, 8'h00);
      wr(3'h0, 8'(d));
      wr(3'h2, {6'h00, m == 2'h1, 1'b0});
      wr(3'h3, {1'b0, m[1], 4'h0, m == 2'h2, k[2]});
      run <= (m == 2'h3);
      repeat (8) @(posedge clk);
      chk(mode, m);
      chk(st, fac(m));
      chk({7'h00, oe_n}, {7'h00, m != 2'h2});
      chk({7'h00, en}, 8'h01);
      rd(3'h5, v);
      chk({6'h00, v[1:0]}, {6'h00, m});
      a = nrx;
      b = ntx;
      c = nrs;
      e = npo;
      f = nch;
      repeat ((d + 1) * 64) @(posedge clk);
      chkn(nrx - a, 64);
      chkn(ntx - b, 64 / fac(m));
      chkn(nrs - c, m[1] ? 32 : 0);
      chkn(npo - e, m == 2'h2 ? 64 : 0);
      chkn(nch - f, 64 / fac(m));
      run <= 1'b0;
    end
    // Let the last slave edge drain before cutting power
    repeat (8) @(posedge clk);
    wr(3'h4, 8'h01);
    @(posedge clk);
    a = nrx;
    repeat (40) @(posedge clk);
    chkn(nrx - a, 0);
    chk({7'h00, en}, 8'h00);
    conclude();
  end
endmodule // ucg_clock_gen_tb
`default_nettype wire
